// File: core/sra_pkg.sv
/*
  constants, carrier types and states for the shared record array.
  assumes one 250 mhz clock and a plain strobe-style parameter port.
*/
// What this block does
// - one store of 800 signed 32-bit records serves capture, compare and cam.
// - every access names a record index, valid only from 0 to 799.
// - writing 30 then 35 to the backup command arms a save at power-down.
// - after every power-up the records reload from the nonvolatile copy.
// - records are reached only through amount, index and the two windows.
// - monitor code 109 reports the capacity in 32-bit words.
// - keypad window one reads keep the index; writes store then step it.
// - link window one reads and writes act on the record then step it.
// - keypad window two reads step the index; keypad writes are refused.
// - nothing else reaches the records; the amount reads the capacity.
package sra_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int          SRA_DEPTH     = 800;
  localparam int          SRA_AW        = 10;
  localparam logic [9:0]  SRA_LAST_IDX  = 10'h31F;
  localparam logic [9:0]  SRA_WALK_END  = 10'h320;
  localparam logic [31:0] SRA_CAPACITY  = 32'h0000_0320;

  // ----------------------------------------------------------------
  // parameter map
  // ----------------------------------------------------------------
  localparam logic [15:0] SRA_OFS_BACKUP = 16'h0208;
  localparam logic [15:0] SRA_OFS_AMOUNT = 16'h050A;
  localparam logic [15:0] SRA_OFS_INDEX  = 16'h050B;
  localparam logic [15:0] SRA_OFS_WIN1   = 16'h050C;
  localparam logic [15:0] SRA_OFS_WIN2   = 16'h050D;
  localparam logic [15:0] SRA_OFS_MON    = 16'h006D;
  localparam logic [15:0] SRA_OFS_STATUS = 16'h0F00;

  // ----------------------------------------------------------------
  // values and fields
  // ----------------------------------------------------------------
  localparam logic [31:0] SRA_BACKUP_STEP1 = 32'h0000_001E;
  localparam logic [31:0] SRA_BACKUP_STEP2 = 32'h0000_0023;
  localparam logic [31:0] SRA_RST_WORD     = 32'h0000_0000;
  localparam int          SRA_ST_ARMED     = 0;
  localparam int          SRA_ST_RESTORE   = 1;
  localparam int          SRA_ST_SAVE      = 2;
  localparam int          SRA_ST_REJECT    = 3;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        we;
    logic [9:0]  addr;
    logic [31:0] data;
  } sra_wr_t;

  typedef enum logic [1:0] {
    SRA_RESTORE,
    SRA_IDLE,
    SRA_SAVE
  } sra_state_t;

endpackage

// File: core/sra_store.sv
/*
  the 800-record storage array: one write port, one combinational read.
  assumes the owner never writes and walks the same record out of order.
*/
`timescale 1ns/10ps
module sra_store
  import sra_pkg::*;
(
  input  wire logic        mclk,
  input  wire sra_wr_t     wr,
  input  wire logic [9:0]  raddr,
  output logic      [31:0] rdata
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // no reset: contents come from the nonvolatile copy after power-up
  logic [31:0] mem [SRA_DEPTH];

  always_ff @(posedge mclk)
  begin
    if (wr.we)
    begin
      mem[wr.addr] <= wr.data;
    end
  end

  // out-of-range addresses read as zero rather than off the end
  assign rdata = (raddr <= SRA_LAST_IDX) ? mem[raddr] : SRA_RST_WORD;

endmodule // sra_store

// File: core/sra_array.sv
/*
  shared record array: parameter port, index and windows, backup arming,
  power-up reload and power-down save toward a nonvolatile memory.
  assumes the nonvolatile memory answers a read in the next cycle and
  takes one write per cycle.
*/
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module sra_array
  import sra_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic [15:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  input  wire logic        from_keypad,
  output logic      [31:0] rdata,
  input  wire logic        power_down,
  output logic             nv_rd,
  output logic             nv_wr,
  output logic      [9:0]  nv_addr,
  output logic      [31:0] nv_wdata,
  input  wire logic [31:0] nv_rdata,
  output logic             save_armed
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sra_state_t  state_reg;
  logic [9:0]  cnt_reg;
  logic        pend_reg;
  logic [9:0]  pend_addr_reg;
  logic [31:0] idx_reg;
  logic [31:0] backup_reg;
  logic        step1_seen_reg;
  logic        armed_reg;
  logic        reject_reg;
  logic [31:0] rdata_reg;
  logic [31:0] ram_q;
  logic [9:0]  ram_raddr;
  sra_wr_t     ram_wr;

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  logic hit_win1;
  logic hit_win2;
  logic in_range;
  logic win_rd;
  logic win_wr;
  logic step_idx;
  logic refuse;
  logic reject_set;
  logic reject_clr;

  assign hit_win1 = (addr == SRA_OFS_WIN1);
  assign hit_win2 = (addr == SRA_OFS_WIN2);
  assign in_range = (idx_reg < SRA_CAPACITY);
  // keypad writes to the second window never store
  assign refuse   = wr_stb && hit_win2 && from_keypad;
  assign win_rd   = rd_stb && (hit_win1 || hit_win2);
  assign win_wr   = wr_stb && (hit_win1 || hit_win2) && !refuse;

  always_comb
  begin
    step_idx = 1'b0;
    if ((state_reg == SRA_IDLE) && in_range)
    begin
      if (win_wr)
      begin
        step_idx = 1'b1;
      end
      else if (win_rd && hit_win1 && !from_keypad)
      begin
        step_idx = 1'b1;
      end
      else if (win_rd && hit_win2)
      begin
        step_idx = 1'b1;
      end
    end
  end

  // refused while busy walking, out of range, or a barred keypad write
  assign reject_set = refuse
                   || ((win_rd || win_wr)
                       && (!in_range || (state_reg != SRA_IDLE)));
  assign reject_clr = wr_stb && (addr == SRA_OFS_STATUS)
                   && wdata[SRA_ST_REJECT];

  // ----------------------------------------------------------------
  // record store
  // ----------------------------------------------------------------
  assign ram_raddr = (state_reg == SRA_SAVE) ? cnt_reg : idx_reg[9:0];

  always_comb
  begin
    ram_wr = '{we: 1'b0, addr: idx_reg[9:0], data: wdata};
    if (state_reg == SRA_RESTORE)
    begin
      ram_wr = '{we: pend_reg, addr: pend_addr_reg, data: nv_rdata};
    end
    else if ((state_reg == SRA_IDLE) && win_wr && in_range)
    begin
      ram_wr.we = 1'b1;
    end
  end

  sra_store u_store (
    .mclk  (mclk),
    .wr    (ram_wr),
    .raddr (ram_raddr),
    .rdata (ram_q)
  );

  // ----------------------------------------------------------------
  // reload and save walks
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg     <= SRA_RESTORE;
      cnt_reg       <= '0;
      pend_reg      <= 1'b0;
      pend_addr_reg <= '0;
    end
    else
    begin
      pend_reg      <= 1'b0;
      pend_addr_reg <= cnt_reg;
      case (state_reg)
        SRA_RESTORE:
        begin
          // no host command needed: the walk starts on reset release
          if (cnt_reg != SRA_WALK_END)
          begin
            pend_reg <= 1'b1;
            cnt_reg  <= cnt_reg + 10'h001;
          end
          else if (!pend_reg)
          begin
            state_reg <= SRA_IDLE;
            cnt_reg   <= '0;
          end
        end
        SRA_IDLE:
        begin
          if (armed_reg && power_down)
          begin
            state_reg <= SRA_SAVE;
            cnt_reg   <= '0;
          end
        end
        SRA_SAVE:
        begin
          if (cnt_reg == SRA_LAST_IDX)
          begin
            state_reg <= SRA_IDLE;
            cnt_reg   <= '0;
          end
          else
          begin
            cnt_reg <= cnt_reg + 10'h001;
          end
        end
        default:
        begin
          state_reg <= SRA_IDLE;
        end
      endcase
    end
  end

  assign nv_rd    = (state_reg == SRA_RESTORE) && (cnt_reg != SRA_WALK_END);
  assign nv_wr    = (state_reg == SRA_SAVE);
  assign nv_addr  = cnt_reg;
  assign nv_wdata = ram_q;

  // ----------------------------------------------------------------
  // index
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      idx_reg <= SRA_RST_WORD;
    end
    else if (wr_stb && (addr == SRA_OFS_INDEX))
    begin
      idx_reg <= wdata;
    end
    else if (step_idx)
    begin
      idx_reg <= idx_reg + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // backup command and arming
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      backup_reg     <= SRA_RST_WORD;
      step1_seen_reg <= 1'b0;
    end
    else if (wr_stb && (addr == SRA_OFS_BACKUP))
    begin
      backup_reg     <= wdata;
      step1_seen_reg <= (wdata == SRA_BACKUP_STEP1);
    end
  end

  // an armed save fires once; a drive left powered keeps it armed
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      armed_reg <= 1'b0;
    end
    else if (wr_stb && (addr == SRA_OFS_BACKUP)
             && step1_seen_reg && (wdata == SRA_BACKUP_STEP2))
    begin
      armed_reg <= 1'b1;
    end
    else if ((state_reg == SRA_SAVE) && (cnt_reg == SRA_LAST_IDX))
    begin
      armed_reg <= 1'b0;
    end
  end

  assign save_armed = armed_reg;

  // ----------------------------------------------------------------
  // refused-access flag, set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      reject_reg <= 1'b0;
    end
    else if (reject_set)
    begin
      reject_reg <= 1'b1;
    end
    else if (reject_clr)
    begin
      reject_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read data, valid the cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_reg <= SRA_RST_WORD;
    end
    else if (rd_stb)
    begin
      case (addr)
        SRA_OFS_BACKUP: rdata_reg <= backup_reg;
        SRA_OFS_AMOUNT: rdata_reg <= SRA_CAPACITY;
        SRA_OFS_MON:    rdata_reg <= SRA_CAPACITY;
        SRA_OFS_INDEX:  rdata_reg <= idx_reg;
        SRA_OFS_WIN1,
        SRA_OFS_WIN2:
        begin
          rdata_reg <= (in_range && (state_reg == SRA_IDLE))
                     ? ram_q : SRA_RST_WORD;
        end
        SRA_OFS_STATUS:
        begin
          rdata_reg <= SRA_RST_WORD;
          rdata_reg[SRA_ST_ARMED]   <= armed_reg;
          rdata_reg[SRA_ST_RESTORE] <= (state_reg == SRA_RESTORE);
          rdata_reg[SRA_ST_SAVE]    <= (state_reg == SRA_SAVE);
          rdata_reg[SRA_ST_REJECT]  <= reject_reg;
        end
        // unmapped offsets read zero
        default:        rdata_reg <= SRA_RST_WORD;
      endcase
    end
    else
    begin
      rdata_reg <= SRA_RST_WORD;
    end
  end

  assign rdata = rdata_reg;

endmodule // sra_array

// File: sim/sra_nv_model.sv
/*
  nonvolatile copy model seen by the shared record array.
  assumes a read answers in the next cycle, one write per cycle.
*/
`timescale 1ns/10ps
module sra_nv_model
(
  input  wire logic        mclk,
  input  wire logic        nv_rd,
  input  wire logic        nv_wr,
  input  wire logic [9:0]  nv_addr,
  input  wire logic [31:0] nv_wdata,
  output logic      [31:0] nv_rdata
);
  logic [31:0] mem [800];
  initial
  begin
    for (int i = 0; i < 800; i++)
      mem[i] = 32'hA5A5_0000 + i;
  end
  // data toggles when not asked, so a late sample never looks right
  always @(posedge mclk)
  begin
    nv_rdata <= nv_rd ? mem[nv_addr] : ~nv_rdata;
    if (nv_wr)
      mem[nv_addr] <= nv_wdata;
  end
endmodule // sra_nv_model

// File: sim/sra_array_asserts.sv
/*
  port checker for the shared record array.
  assumes it is bound to sra_array and sees only its ports.
*/
`timescale 1ns/10ps
module sra_array_asserts
  import sra_pkg::*;
(
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic [15:0] addr,
  input wire logic [31:0] wdata,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [31:0] rdata,
  input wire logic        power_down,
  input wire logic        nv_rd,
  input wire logic        nv_wr,
  input wire logic [9:0]  nv_addr,
  input wire logic        save_armed
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  chk_rdata_idle: assert property (!$past(rd_stb) |-> rdata == 32'h0)
    else $error("read data not zero outside a read");
  chk_amount_read: assert property (rd_stb && addr == SRA_OFS_AMOUNT
    |=> rdata == SRA_CAPACITY) else $error("amount read wrong");
  chk_monitor_read: assert property (rd_stb && addr == SRA_OFS_MON
    |=> rdata == SRA_CAPACITY) else $error("capacity monitor wrong");
  chk_arm_cause: assert property ($rose(save_armed) |-> $past(wr_stb
    && addr == SRA_OFS_BACKUP && wdata == SRA_BACKUP_STEP2))
    else $error("save armed without second backup step");
  chk_save_start: assert property (save_armed && power_down && !nv_rd
    && !nv_wr |=> nv_wr && nv_addr == 10'h000) else $error("save not started");
  chk_save_step: assert property (nv_wr && $past(nv_wr)
    |-> nv_addr == $past(nv_addr) + 10'h001) else $error("save address skip");
  chk_save_end: assert property (nv_wr && nv_addr == SRA_LAST_IDX
    |=> !nv_wr && !save_armed) else $error("save did not end");
  chk_reload_step: assert property (nv_rd && nv_addr != 10'h000
    |-> $past(nv_rd) && nv_addr == $past(nv_addr) + 10'h001)
    else $error("reload address skip");
  chk_reload_end: assert property (nv_rd && nv_addr == SRA_LAST_IDX
    |=> !nv_rd) else $error("reload did not end");
endmodule // sra_array_asserts

bind sra_array sra_array_asserts chk_u (.mclk(mclk), .nrst(nrst),
  .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .rdata(rdata), .power_down(power_down), .nv_rd(nv_rd), .nv_wr(nv_wr),
  .nv_addr(nv_addr), .save_armed(save_armed));

// File: sim/testbench.sv
/*
  self-checking bench for the shared record array.
  assumes the nonvolatile model answers the reload and takes the save.
*/
`timescale 1ns/10ps
module testbench;
  import sra_pkg::*;
  logic        mclk, nrst, wr_stb, rd_stb, from_keypad, power_down;
  logic        nv_rd, nv_wr, save_armed;
  logic        rd_d = 1'b0;
  logic [15:0] addr;
  logic [31:0] wdata, rdata, nv_wdata, nv_rdata;
  logic [9:0]  nv_addr;
  logic [31:0] exp_q [$];
  logic [31:0] d [3];
  int          n_mismatch, n_compared;

  sra_array dut_u (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .from_keypad(from_keypad),
    .rdata(rdata), .power_down(power_down), .nv_rd(nv_rd), .nv_wr(nv_wr),
    .nv_addr(nv_addr), .nv_wdata(nv_wdata), .nv_rdata(nv_rdata),
    .save_armed(save_armed));
  sra_nv_model nv_u (.mclk(mclk), .nv_rd(nv_rd), .nv_wr(nv_wr),
    .nv_addr(nv_addr), .nv_wdata(nv_wdata), .nv_rdata(nv_rdata));

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------
  // bus cycles
  // ----------
  // reads leave their expected word for the monitor
  task automatic acc(input logic w, input logic [15:0] a,
                     input logic [31:0] v, input logic kp);
    @(posedge mclk);
    wr_stb <= w;
    rd_stb <= !w;
    addr <= a;
    wdata <= v;
    from_keypad <= kp;
    if (!w)
      exp_q.push_back(v);
    // strobes are one cycle long: drop them once the edge has taken them
    @(posedge mclk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
  endtask

  task automatic idle();
    @(posedge mclk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
  endtask

  // bounded: a stuck walk counts as a mismatch
  task automatic wait_walk();
    int k;
    k = 0;
    while ((nv_rd || nv_wr) && k < 2000)
    begin
      @(posedge mclk);
      k++;
    end
    if (k == 2000)
      n_mismatch++;
    idle();
  endtask

  task automatic do_reset();
    nrst <= 1'b0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
  endtask

  always @(posedge mclk)
  begin
    if (rd_d)
      cmp(rdata, exp_q.pop_front());
    rd_d <= rd_stb;
  end

  initial
  begin
    #40000;
    n_mismatch++;
    end_sim();
  end

  initial
  begin
    {nrst, wr_stb, rd_stb, from_keypad, power_down} = 5'h00;
    addr = 16'h0000;
    wdata = 32'h0000_0000;
    void'($urandom(32'h25b3d9d6));
    foreach (d[i])
      d[i] = $urandom;
    do_reset();
    acc(0, SRA_OFS_WIN1, 32'h0000_0000, 0);
    acc(0, SRA_OFS_STATUS, 32'h0000_000A, 0);
    wait_walk();
    acc(1, SRA_OFS_STATUS, 32'h0000_0008, 0);
    acc(0, SRA_OFS_STATUS, 32'h0000_0000, 0);
    for (int i = 0; i < 2; i++)
      acc(0, SRA_OFS_WIN1, 32'hA5A5_0000 + i, 0);
    acc(0, SRA_OFS_INDEX, 32'h0000_0002, 0);
    $display("reload test done");
    acc(1, SRA_OFS_AMOUNT, $urandom, 0);
    acc(0, SRA_OFS_AMOUNT, SRA_CAPACITY, 0);
    acc(0, SRA_OFS_MON, SRA_CAPACITY, 1);
    acc(0, 16'h0123, 32'h0000_0000, 0);
    $display("register test done");
    acc(1, SRA_OFS_INDEX, 32'h0000_000B, 1);
    foreach (d[i])
      acc(1, SRA_OFS_WIN1, d[i], 1);
    acc(0, SRA_OFS_INDEX, 32'h0000_000E, 0);
    acc(1, SRA_OFS_INDEX, 32'h0000_000B, 0);
    acc(0, SRA_OFS_WIN1, d[0], 1);
    acc(0, SRA_OFS_WIN1, d[0], 1);
    acc(0, SRA_OFS_INDEX, 32'h0000_000B, 0);
    foreach (d[i])
      acc(0, SRA_OFS_WIN2, d[i], 1);
    acc(0, SRA_OFS_INDEX, 32'h0000_000E, 0);
    acc(1, SRA_OFS_INDEX, 32'h0000_000B, 0);
    acc(1, SRA_OFS_WIN2, ~d[0], 1);
    acc(0, SRA_OFS_INDEX, 32'h0000_000B, 0);
    acc(0, SRA_OFS_STATUS, 32'h0000_0008, 0);
    acc(1, SRA_OFS_STATUS, 32'h0000_0008, 0);
    acc(0, SRA_OFS_WIN1, d[0], 0);
    acc(0, SRA_OFS_INDEX, 32'h0000_000C, 0);
    $display("window test done");
    acc(1, SRA_OFS_INDEX, 32'h0000_031F, 0);
    acc(1, SRA_OFS_WIN1, d[1], 0);
    acc(1, SRA_OFS_WIN1, d[2], 0);
    acc(0, SRA_OFS_INDEX, 32'h0000_0320, 0);
    // an index past 1023 must not alias back onto record 0
    acc(1, SRA_OFS_INDEX, 32'h0000_0400, 0);
    acc(1, SRA_OFS_WIN1, d[0], 0);
    acc(1, SRA_OFS_INDEX, 32'h0000_0000, 0);
    acc(0, SRA_OFS_WIN1, 32'hA5A5_0000, 1);
    acc(0, SRA_OFS_STATUS, 32'h0000_0008, 0);
    acc(1, SRA_OFS_STATUS, 32'h0000_0008, 0);
    acc(1, SRA_OFS_INDEX, 32'h0000_031F, 0);
    acc(0, SRA_OFS_WIN1, d[1], 1);
    $display("range test done");
    acc(1, SRA_OFS_BACKUP, SRA_BACKUP_STEP1, 0);
    acc(1, SRA_OFS_BACKUP, 32'h0000_001F, 0);
    acc(1, SRA_OFS_BACKUP, SRA_BACKUP_STEP2, 0);
    idle();
    idle();
    cmp({31'h0, save_armed}, 32'h0000_0000);
    acc(1, SRA_OFS_BACKUP, SRA_BACKUP_STEP1, 0);
    acc(1, SRA_OFS_BACKUP, SRA_BACKUP_STEP2, 0);
    idle();
    idle();
    cmp({31'h0, save_armed}, 32'h0000_0001);
    acc(0, SRA_OFS_STATUS, 32'h0000_0001, 0);
    power_down <= 1'b1;
    repeat (2) idle();
    wait_walk();
    cmp({31'h0, save_armed}, 32'h0000_0000);
    power_down <= 1'b0;
    do_reset();
    wait_walk();
    acc(1, SRA_OFS_INDEX, 32'h0000_000B, 0);
    foreach (d[i])
      acc(0, SRA_OFS_WIN2, d[i], 1);
    acc(0, SRA_OFS_WIN1, 32'hA5A5_000E, 1);
    repeat (3) idle();
    $display("backup test done");
    end_sim();
  end
endmodule // testbench
